// >>> ramp_start_sync_unit_test.sv
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        n_compared++; \
        if ((a) !== (b)) \
        begin \
            err_total++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, a, b); \
        end \
    end
module ramp_start_sync_unit_test;
    logic i_clk;
    logic i_rst;
    logic i_reg_wr;
    logic [6:0] i_reg_addr;
    logic [31:0] i_reg_wdata;
    logic [6:0] i_rd_addr;
    logic [2:0] ev;
    logic fire;
    logic pol;
    logic line;
    logic start;
    logic shload;
    logic pin;
    logic oe;
    logic [31:0] rd_data;
    logic [31:0] goal;
    logic [31:0] speed;
    logic [31:0] prof;
    logic [31:0] scale;
    int err_total;
    int n_compared;
    int n;
    rssu_ramp_start_sync dut (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_reg_wr(i_reg_wr),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .i_rd_addr(i_rd_addr),
        .o_rd_data(rd_data),
        .i_pos_arrived(ev[0]),
        .i_speed_arrived(ev[1]),
        .i_compare_match_event(ev[2]),
        .i_start_pin(line),
        .o_start_pin(pin),
        .o_start_pin_oe(oe),
        .o_start(start),
        .o_shadow_load(shload),
        .o_goal_position(goal),
        .o_peak_speed(speed),
        .o_profile_select(prof),
        .o_follow_scale(scale)
    );
    rssu_far_end far (
        .i_clk(i_clk),
        .i_pol(pol),
        .i_fire(fire),
        .i_dut_oe(oe),
        .i_dut_pin(pin),
        .o_line(line)
    );
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = !i_clk;
    end
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    // Counts edges up to the first start pulse, giving up at lim.
    task automatic wait_start(input int lim, output int c);
        c = 0;
        while (c < lim)
        begin
            @(posedge i_clk);
            #1;
            c++;
            if (start === 1'b1)
                break;
        end
    endtask
    task automatic count_starts(input int cyc, output int c);
        c = 0;
        repeat (cyc)
        begin
            @(posedge i_clk);
            #1;
            c += int'(start === 1'b1);
        end
    endtask
    task automatic t_regs;
        @(posedge i_clk);
        i_rd_addr <= rssu_pkg::ADDR_SYNC_SETUP;
        @(posedge i_clk);
        #1;
        `CHK(rd_data, rssu_pkg::SYNC_SETUP_RST)
        wr(rssu_pkg::ADDR_GOAL_POSITION, 32'h55);
        #1;
        `CHK(goal, 32'h55)
        @(posedge i_clk);
        i_rd_addr <= rssu_pkg::ADDR_GOAL_POSITION;
        @(posedge i_clk);
        #1;
        `CHK(rd_data, 32'h55)
    endtask
    task automatic t_events;
        for (int k = 0; k < 3; k++)
        begin
            wr(rssu_pkg::ADDR_SYNC_SETUP, 32'h40 << k);
            wr(rssu_pkg::ADDR_LAUNCH_WAIT, 32'h3);
            ev[k] <= 1'b1;
            wait_start(20, n);
            `CHK(n, 4)
            count_starts(12, n);
            `CHK(n, 0)
            @(posedge i_clk);
            ev[k] <= 1'b0;
        end
    endtask
    task automatic t_mix;
        wr(rssu_pkg::ADDR_SYNC_SETUP, 32'h1c0);
        wr(rssu_pkg::ADDR_LAUNCH_WAIT, 32'h0);
        ev[2] <= 1'b1;
        wait_start(20, n);
        `CHK(n, 1)
        @(posedge i_clk);
        ev[2] <= 1'b0;
        wr(rssu_pkg::ADDR_SYNC_SETUP, 32'h0);
        ev <= 3'h7;
        count_starts(10, n);
        `CHK(n, 0)
        @(posedge i_clk);
        ev <= 3'h0;
    endtask
    task automatic t_defer;
        wr(rssu_pkg::ADDR_SYNC_SETUP, 32'h5f);
        wr(rssu_pkg::ADDR_GOAL_POSITION, 32'h11);
        wr(rssu_pkg::ADDR_PEAK_SPEED, 32'h22);
        wr(rssu_pkg::ADDR_PROFILE_SELECT, 32'h33);
        wr(rssu_pkg::ADDR_FOLLOW_SCALE, 32'h44);
        ev[0] <= 1'b1;
        #1;
        `CHK({goal, speed, prof, scale}, {32'h55, 96'h0})
        wait_start(20, n);
        `CHK(shload, 1'b1)
        @(posedge i_clk);
        ev[0] <= 1'b0;
        #1;
        `CHK(goal, 32'h11)
        `CHK(speed, 32'h22)
        `CHK(prof, 32'h33)
        `CHK(scale, 32'h44)
        wr(rssu_pkg::ADDR_SYNC_SETUP, 32'h41);
        wr(rssu_pkg::ADDR_PEAK_SPEED, 32'h66);
        wr(rssu_pkg::ADDR_GOAL_POSITION, 32'h77);
        #1;
        `CHK({speed, goal}, {32'h66, 32'h11})
    endtask
    task automatic t_pin_out;
        wr(rssu_pkg::ADDR_PULSE_EXTEND, 32'h2);
        for (int p = 0; p < 2; p++)
        begin
            wr(rssu_pkg::ADDR_SYNC_SETUP, 32'h40 | (p << 9));
            pol <= p[0];
            repeat (4) @(posedge i_clk);
            ev[0] <= 1'b1;
            wait_start(20, n);
            `CHK({oe, pin, line}, {1'b1, p[0], p[0]})
            count_starts(2, n);
            `CHK(pin, p[0])
            @(posedge i_clk);
            ev[0] <= 1'b0;
            #1;
            `CHK(pin, !p[0])
        end
    endtask
    task automatic t_pin_in;
        pol <= 1'b0;
        wr(rssu_pkg::ADDR_LAUNCH_WAIT, 32'd20);
        wr(rssu_pkg::ADDR_SYNC_SETUP, 32'h20);
        repeat (3) @(posedge i_clk);
        fire <= 1'b1;
        wait_start(60, n);
        `CHK({oe, n > 20 && n < 40}, 2'b01)
        @(posedge i_clk);
        fire <= 1'b0;
        wr(rssu_pkg::ADDR_SYNC_SETUP, 32'h460);
        repeat (3) @(posedge i_clk);
        ev[0] <= 1'b1;
        repeat (2) @(posedge i_clk);
        fire <= 1'b1;
        wait_start(60, n);
        `CHK(n < 8, 1'b1)
        count_starts(30, n);
        `CHK(n, 0)
        @(posedge i_clk);
        fire <= 1'b0;
        ev[0] <= 1'b0;
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        {i_rst, i_reg_wr, i_reg_addr, i_reg_wdata} = {2'b10, 39'h0};
        {i_rd_addr, ev, fire, pol} = 12'h0;
        err_total = 0;
        n_compared = 0;
        repeat (4) @(posedge i_clk);
        #1;
        `CHK(pin, 1'b1)
        @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs;
        t_events;
        t_mix;
        t_defer;
        t_pin_out;
        t_pin_in;
        stop_test;
    end
    initial
    begin
        repeat (3000) @(posedge i_clk);
        err_total++;
        stop_test;
    end
endmodule

// >>> rssu_far_end.sv
`timescale 1ns/1ps
module rssu_far_end (
    input wire logic i_clk,
    input wire logic i_pol,
    input wire logic i_fire,
    input wire logic i_dut_oe,
    input wire logic i_dut_pin,
    output logic o_line
);
    logic fire_q;
    // A peer launches from a register, one clock after it is asked.
    always @(posedge i_clk)
        fire_q <= i_fire;
    assign o_line = i_dut_oe ? i_dut_pin : (fire_q ~^ i_pol);
endmodule

// >>> rssu_param_reg.sv
`timescale 1ns/1ps
// One parameter word with an optional deferred update path.
module rssu_param_reg #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_wr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_defer,
    input wire logic i_start,
    // Values
    output logic [WIDTH-1:0] o_active,
    output logic o_pending
);
    typedef struct packed {
        logic [WIDTH-1:0] active;
        logic [WIDTH-1:0] buffer;
        logic pend;
    } rssu_preg_t;

    rssu_preg_t st_q;
    rssu_preg_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (i_start && st_q.pend)
        begin
            st_d.active = st_q.buffer;
            st_d.pend = 1'b0;
        end
        if (i_wr)
        begin
            if (i_defer)
            begin
                // Value parked until the next start.
                st_d.buffer = i_wdata;
                st_d.pend = 1'b1;
            end
            else
            begin
                st_d.active = i_wdata;
                st_d.pend = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_active = st_q.active;
    assign o_pending = st_q.pend;
endmodule

// >>> rssu_pkg.sv
package rssu_pkg;

    // Register indices as seen by the register port.
    localparam logic [6:0] ADDR_SYNC_SETUP = 7'h02;
    localparam logic [6:0] ADDR_PULSE_EXTEND = 7'h11;
    localparam logic [6:0] ADDR_LAUNCH_WAIT = 7'h13;
    localparam logic [6:0] ADDR_GOAL_POSITION = 7'h37;
    localparam logic [6:0] ADDR_PEAK_SPEED = 7'h27;
    localparam logic [6:0] ADDR_PROFILE_SELECT = 7'h20;
    localparam logic [6:0] ADDR_FOLLOW_SCALE = 7'h12;

    // Field positions inside sync_setup.
    localparam int DEFER_LSB = 0;
    localparam int TRIG_LSB = 5;
    localparam int POL_BIT = 9;
    localparam int BYPASS_BIT = 10;

    // Deferred write switch positions.
    localparam int DEFER_GOAL = 0;
    localparam int DEFER_SPEED = 1;
    localparam int DEFER_PROFILE = 2;
    localparam int DEFER_SCALE = 3;
    localparam int DEFER_SHADOW = 4;

    // Trigger source positions.
    localparam int TRIG_PIN = 0;
    localparam int TRIG_POS = 1;
    localparam int TRIG_VEL = 2;
    localparam int TRIG_CMP = 3;

    // Values after reset.
    localparam logic [31:0] SYNC_SETUP_RST = 32'h0000_0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        RSSU_IDLE,
        RSSU_WAIT
    } rssu_state_t;

endpackage

// >>> rssu_props.sv
`timescale 1ns/1ps
module rssu_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register writes
    input wire logic i_reg_wr,
    input wire logic [6:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    // Ramp side and pin
    input wire logic o_start,
    input wire logic o_shadow_load,
    input wire logic o_start_pin,
    input wire logic o_start_pin_oe,
    input wire logic [31:0] o_goal_position
);
    logic [31:0] cfg_q;
    logic [31:0] ext_q;
    logic [2:0] calm_q;
    logic [31:0] run_q;
    logic act;
    logic calm;
    logic cfg_wr;
    assign cfg_wr = i_reg_wr && i_reg_addr == rssu_pkg::ADDR_SYNC_SETUP;
    assign act = o_start_pin == cfg_q[rssu_pkg::POL_BIT];
    // Checks pause a few cycles after a setup change, which may land late.
    assign calm = calm_q == 3'h4;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cfg_q <= 32'h0;
            ext_q <= 32'h0;
            calm_q <= 3'h0;
            run_q <= 32'h0;
        end
        else
        begin
            if (cfg_wr)
                cfg_q <= i_reg_wdata;
            calm_q <= cfg_wr ? 3'h0 : (calm ? calm_q : calm_q + 3'h1);
            if (i_reg_wr && i_reg_addr == rssu_pkg::ADDR_PULSE_EXTEND)
                ext_q <= i_reg_wdata;
            run_q <= act ? run_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    chk_src_zero_idle: assert property (calm && cfg_q[8:5] == 4'h0
        |-> !o_start) else $error("start with no source enabled");
    chk_pin_dir: assert property (calm |-> o_start_pin_oe ==
        (cfg_q[8:5] != 4'h0 && !cfg_q[5])) else $error("pin direction");
    chk_pin_pulse_len: assert property (calm && o_start_pin_oe
        && $fell(act) |-> run_q == ext_q + 32'h1)
        else $error("pin pulse length");
    chk_pin_marks_start: assert property (calm && o_start_pin_oe
        && $rose(act) |-> o_start) else $error("pin pulse without start");
    chk_shadow_gate: assert property (calm && o_start
        |-> o_shadow_load == cfg_q[4]) else $error("shadow load gating");
    chk_shadow_at_start: assert property (o_shadow_load
        |-> o_start) else $error("shadow load outside start");
    chk_goal_now: assert property (calm && i_reg_wr && !cfg_q[0]
        && i_reg_addr == rssu_pkg::ADDR_GOAL_POSITION
        |=> o_goal_position == $past(i_reg_wdata))
        else $error("goal write not applied");
    chk_goal_held: assert property (calm && cfg_q[0] && !o_start
        |=> $stable(o_goal_position)) else $error("deferred goal moved");
endmodule
bind rssu_ramp_start_sync rssu_props u_props (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_start(o_start),
    .o_shadow_load(o_shadow_load),
    .o_start_pin(o_start_pin),
    .o_start_pin_oe(o_start_pin_oe),
    .o_goal_position(o_goal_position)
);

// >>> rssu_ramp_start_sync.sv
`timescale 1ns/1ps
// What this block does
// - Trigger is the edge into active state
// - Start signal follows trigger after delay
// - Trigger source bits 8:5; zero disables
// - Source bit0 clear: pin drives start out
// - Source bit0 set: pin edge triggers
// - Source bit1: position arrival triggers
// - Source bit2: speed arrival triggers
// - Source bit3: compare match triggers
// - Any combination of sources allowed
// - No deferral: writes apply at once
// - Defer bit0: goal position waits start
// - Defer bit1: peak speed waits start
// - Defer bit2: profile select waits start
// - Defer bit3: follow scale waits start
// - Defer bit4: shadow set copied at start
// - Deferral switches act independently
// - Delay length from launch wait count
// - Bypass bit: pin trigger starts immediately
// - Pin active low unless polarity set
// - Output pulse lasts extend plus one
module rssu_ramp_start_sync #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register write port, applied at end of transfer
    input wire logic i_reg_wr,
    input wire logic [6:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    // Register read port
    input wire logic [6:0] i_rd_addr,
    output logic [31:0] o_rd_data,
    // Internal events
    input wire logic i_pos_arrived,
    input wire logic i_speed_arrived,
    input wire logic i_compare_match_event,
    // Start pin
    input wire logic i_start_pin,
    output logic o_start_pin,
    output logic o_start_pin_oe,
    // Ramp side
    output logic o_start,
    output logic o_shadow_load,
    output logic [31:0] o_goal_position,
    output logic [31:0] o_peak_speed,
    output logic [31:0] o_profile_select,
    output logic [31:0] o_follow_scale
);
    typedef struct packed {
        logic [31:0] setup;
        logic [CNT_W-1:0] extend;
        logic [CNT_W-1:0] wait_cnt;
        rssu_pkg::rssu_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] pulse_cnt;
        logic pulse_on;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic [2:0] ev_prev;
        logic start;
        logic shadow;
        logic pin_out;
        logic pin_oe;
        logic [31:0] rd;
    } rssu_top_t;

    rssu_top_t st_q;
    rssu_top_t st_d;
    logic [3:0] trig;
    logic [4:0] defer;
    logic pol;
    logic pin_act;
    logic pin_edge;
    logic [2:0] ev_now;
    logic [2:0] ev_rise;
    logic int_trig;
    logic [31:0] goal_w;
    logic [31:0] speed_w;
    logic [31:0] prof_w;
    logic [31:0] scale_w;

    function automatic logic wr_to(input logic [6:0] a);
        wr_to = i_reg_wr && (i_reg_addr == a);
    endfunction

    // Maps a synchronised pin level to its active sense. Polarity set means
    // the pin is active high.
    function automatic logic pin_is_active(input logic level,
        input logic high_active);
        pin_is_active = high_active ? level : ~level;
    endfunction

    // Read data for one register index. Unmapped indices read as zero, so
    // software can probe the map without side effects.
    function automatic logic [31:0] read_word(input logic [6:0] a);
        case (a)
            rssu_pkg::ADDR_SYNC_SETUP: read_word = st_q.setup;
            rssu_pkg::ADDR_PULSE_EXTEND: read_word = 32'(st_q.extend);
            rssu_pkg::ADDR_LAUNCH_WAIT: read_word = 32'(st_q.wait_cnt);
            rssu_pkg::ADDR_GOAL_POSITION: read_word = goal_w;
            rssu_pkg::ADDR_PEAK_SPEED: read_word = speed_w;
            rssu_pkg::ADDR_PROFILE_SELECT: read_word = prof_w;
            rssu_pkg::ADDR_FOLLOW_SCALE: read_word = scale_w;
            default: read_word = 32'h0000_0000;
        endcase
    endfunction

    // The count runs from one, so the compare is met wait_cnt cycles on.
    function automatic logic delay_done(input logic [CNT_W-1:0] count,
        input logic [CNT_W-1:0] limit);
        delay_done = count >= limit;
    endfunction

    assign trig = st_q.setup[rssu_pkg::TRIG_LSB +: 4];
    assign defer = st_q.setup[rssu_pkg::DEFER_LSB +: 5];
    assign pol = st_q.setup[rssu_pkg::POL_BIT];
    // The previous raw level is kept rather than the mapped one, so that a
    // polarity change on a quiet pin is not taken for an edge.
    assign pin_act = pin_is_active(st_q.pin_s2, pol);
    assign pin_edge = pin_act
        && !pin_is_active(st_q.pin_prev, pol);
    assign ev_now = {i_compare_match_event, i_speed_arrived, i_pos_arrived};
    assign ev_rise = ev_now & ~st_q.ev_prev;
    // Each internal source is gated by its own enable, so that any
    // combination of them may be armed at once.
    function automatic logic event_hit(input logic [3:0] src,
        input logic [2:0] ev_edge);
        event_hit = (ev_edge[0] && src[rssu_pkg::TRIG_POS])
            || (ev_edge[1] && src[rssu_pkg::TRIG_VEL])
            || (ev_edge[2] && src[rssu_pkg::TRIG_CMP]);
    endfunction

    assign int_trig = event_hit(trig, ev_rise);

    always_comb
    begin
        logic ext_trig;
        logic any_trig;
        logic fire;
        ext_trig = 1'b0;
        any_trig = 1'b0;
        fire = 1'b0;
        st_d = st_q;
        st_d.pin_s1 = i_start_pin;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.pin_prev = st_q.pin_s2;
        st_d.ev_prev = ev_now;
        st_d.start = 1'b0;
        st_d.shadow = 1'b0;
        if (wr_to(rssu_pkg::ADDR_SYNC_SETUP))
            st_d.setup = i_reg_wdata;
        if (wr_to(rssu_pkg::ADDR_PULSE_EXTEND))
            st_d.extend = i_reg_wdata[CNT_W-1:0];
        if (wr_to(rssu_pkg::ADDR_LAUNCH_WAIT))
            st_d.wait_cnt = i_reg_wdata[CNT_W-1:0];

        ext_trig = trig[rssu_pkg::TRIG_PIN] && pin_edge;
        any_trig = (trig != 4'h0) && (ext_trig || int_trig);

        case (st_q.state)
            rssu_pkg::RSSU_IDLE:
            begin
                if (any_trig)
                begin
                    if (st_q.wait_cnt == '0)
                        fire = 1'b1;
                    else
                    begin
                        // Count from one so fire lands wait_cnt cycles on.
                        st_d.state = rssu_pkg::RSSU_WAIT;
                        st_d.cnt = CNT_W'(1);
                    end
                end
            end
            rssu_pkg::RSSU_WAIT:
            begin
                // Triggers that come while a delay runs are dropped, except a pin trigger with bypass set.
                if (trig == 4'h0)
                    st_d.state = rssu_pkg::RSSU_IDLE;
                else if (delay_done(st_q.cnt, st_q.wait_cnt))
                begin
                    fire = 1'b1;
                    st_d.state = rssu_pkg::RSSU_IDLE;
                end
                else
                    st_d.cnt = st_q.cnt + CNT_W'(1);
            end
            default:
                st_d.state = rssu_pkg::RSSU_IDLE;
        endcase

        // With the bypass bit set, a pin trigger cuts short a running delay.
        if (ext_trig && st_q.setup[rssu_pkg::BYPASS_BIT])
        begin
            fire = 1'b1;
            st_d.state = rssu_pkg::RSSU_IDLE;
        end

        st_d.start = fire;
        st_d.shadow = fire && defer[rssu_pkg::DEFER_SHADOW];

        // Output pulse of extend+1 cycles while the pin is an output. A new
        // start during a pulse reloads the count rather than being lost.
        if (fire && !trig[rssu_pkg::TRIG_PIN])
        begin
            st_d.pulse_on = 1'b1;
            st_d.pulse_cnt = st_q.extend;
        end
        else if (trig == 4'h0)
            st_d.pulse_on = 1'b0;
        else if (st_q.pulse_on)
        begin
            if (st_q.pulse_cnt == '0)
                st_d.pulse_on = 1'b0;
            else
                st_d.pulse_cnt = st_q.pulse_cnt - CNT_W'(1);
        end
        st_d.pin_oe = (trig != 4'h0) && !trig[rssu_pkg::TRIG_PIN];
        st_d.pin_out = st_d.pulse_on ^ ~pol;

        st_d.rd = read_word(i_rd_addr);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= '0;
            st_q.setup <= rssu_pkg::SYNC_SETUP_RST;
            st_q.state <= rssu_pkg::RSSU_IDLE;
            // Idle pin level is high for the default active-low polarity.
            st_q.pin_out <= 1'b1;
            // Synchroniser and edge history start at that idle level too.
            st_q.pin_s1 <= 1'b1;
            st_q.pin_s2 <= 1'b1;
            st_q.pin_prev <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    // Each word is gated by its own switch.
    rssu_param_reg #(.WIDTH(32)) u_goal (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr(wr_to(rssu_pkg::ADDR_GOAL_POSITION)),
        .i_wdata(i_reg_wdata),
        .i_defer(defer[rssu_pkg::DEFER_GOAL]),
        .i_start(st_q.start),
        .o_active(goal_w),
        .o_pending()
    );

    rssu_param_reg #(.WIDTH(32)) u_speed (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr(wr_to(rssu_pkg::ADDR_PEAK_SPEED)),
        .i_wdata(i_reg_wdata),
        .i_defer(defer[rssu_pkg::DEFER_SPEED]),
        .i_start(st_q.start),
        .o_active(speed_w),
        .o_pending()
    );

    rssu_param_reg #(.WIDTH(32)) u_prof (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr(wr_to(rssu_pkg::ADDR_PROFILE_SELECT)),
        .i_wdata(i_reg_wdata),
        .i_defer(defer[rssu_pkg::DEFER_PROFILE]),
        .i_start(st_q.start),
        .o_active(prof_w),
        .o_pending()
    );

    rssu_param_reg #(.WIDTH(32)) u_scale (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr(wr_to(rssu_pkg::ADDR_FOLLOW_SCALE)),
        .i_wdata(i_reg_wdata),
        .i_defer(defer[rssu_pkg::DEFER_SCALE]),
        .i_start(st_q.start),
        .o_active(scale_w),
        .o_pending()
    );

    assign o_rd_data = st_q.rd;
    assign o_start_pin = st_q.pin_out;
    assign o_start_pin_oe = st_q.pin_oe;
    assign o_start = st_q.start;
    assign o_shadow_load = st_q.shadow;
    assign o_goal_position = goal_w;
    assign o_peak_speed = speed_w;
    assign o_profile_select = prof_w;
    assign o_follow_scale = scale_w;
endmodule
